// file: hw/vrh_command_unit.sv
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module vrh_command_unit import vrh_pkg::*; #(
  parameter logic [19:0] RAM_LAST = RAM_LAST_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic host_mode_pin_in,
  input wire logic init_pulse_pin_n_in,
  input wire logic [3:0] host_nibble_bus_in,
  output logic [3:0] host_nibble_bus_out,
  output logic host_nibble_bus_oe_n_out,
  input wire logic host_wr_n_in,
  input wire logic host_rd_n_in,
  input wire logic sample_tick_in,
  input wire logic amplitude_in,
  input wire logic [7:0] ram_rdata_in,
  output vrh_ram_req_t ram_req_out,
  output logic [1:0] rate_sel_out,
  output logic record_mode_out,
  output logic codec_run_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  function automatic logic [7:0] byte_of(input logic [19:0] v, input logic [1:0] sel);
    unique case (sel)
      2'h0: byte_of = v[7:0];
      2'h1: byte_of = v[15:8];
      default: byte_of = {4'h0, v[19:16]};
    endcase
  endfunction : byte_of

  function automatic logic [19:0] put_byte(input logic [19:0] v, input logic [1:0] sel,
                                           input logic [7:0] b);
    unique case (sel)
      2'h0: put_byte = {v[19:8], b};
      2'h1: put_byte = {v[19:16], b, v[7:0]};
      default: put_byte = {b[3:0], v[15:0]};
    endcase
  endfunction : put_byte

  // pin synchronisers
  logic [3:0] nib_s1_ff, nib_s2_ff;
  logic wr_s1_ff, wr_s2_ff, wr_d_ff, rd_s1_ff, rd_s2_ff, rd_d_ff;
  logic mode_s1_ff, mode_s2_ff, init_s1_ff, init_s2_ff, init_d_ff;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      nib_s1_ff <= 4'h0;
      nib_s2_ff <= 4'h0;
      {wr_s1_ff, wr_s2_ff, wr_d_ff} <= 3'h7;
      {rd_s1_ff, rd_s2_ff, rd_d_ff} <= 3'h7;
      {mode_s1_ff, mode_s2_ff} <= 2'h0;
      {init_s1_ff, init_s2_ff, init_d_ff} <= 3'h7;
    end else begin
      nib_s1_ff <= host_nibble_bus_in;
      nib_s2_ff <= nib_s1_ff;
      wr_s1_ff <= host_wr_n_in;
      wr_s2_ff <= wr_s1_ff;
      wr_d_ff <= wr_s2_ff;
      rd_s1_ff <= host_rd_n_in;
      rd_s2_ff <= rd_s1_ff;
      rd_d_ff <= rd_s2_ff;
      mode_s1_ff <= host_mode_pin_in;
      mode_s2_ff <= mode_s1_ff;
      init_s1_ff <= init_pulse_pin_n_in;
      init_s2_ff <= init_s1_ff;
      init_d_ff <= init_s2_ff;
    end
  end

  logic host_en_ff, soft_init_ff;
  logic host_ok, wr_evt, rd_evt, init_req;
  assign host_ok = mode_s2_ff & host_en_ff;
  assign wr_evt = wr_s2_ff & ~wr_d_ff & host_ok;
  assign rd_evt = rd_s2_ff & ~rd_d_ff & host_ok;
  assign init_req = (~init_s2_ff & init_d_ff) | soft_init_ff;

  vrh_state_t state_ff;
  logic [3:0] cmd_ff;
  logic [2:0] need_ff, nib_cnt_ff, step_ff, smp_ff, rb_left_ff;
  logic [19:0] asm_ff, cnt_ff, stop_ff, wval_ff, rb_ff;
  logic [7:0] idx_ff, wbase_ff, init_addr_ff;
  logic [1:0] rate_ff;
  logic ovf_en_ff, rec_mode_ff, full_ff, label_ff, go_run_ff, fetch_pend_ff;
  vrh_ram_req_t ram_req_ff;
  logic [3:0] status_ff, nib_out_ff;
  logic nib_oe_n_ff;

  logic [19:0] nxt_asm;
  logic [7:0] slot_base;
  logic [2:0] prev_step;
  logic ovf_hit, cmp_hit, stop_cmd, start_cmd;
  assign nxt_asm = {nib_s2_ff, asm_ff[19:4]};
  assign slot_base = {nxt_asm[17:12], 2'h0};
  assign prev_step = step_ff - 3'h1;
  assign ovf_hit = rec_mode_ff & ovf_en_ff & (cnt_ff == RAM_LAST);
  assign cmp_hit = (cnt_ff == stop_ff) & ~(rec_mode_ff & label_ff);
  assign stop_cmd = wr_evt & (nib_s2_ff == CMD_STOP);
  assign start_cmd = wr_evt & (nib_s2_ff == CMD_START);

  // command sequencer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff <= S_INIT;
      cmd_ff <= 4'h0;
      need_ff <= 3'h0;
      nib_cnt_ff <= 3'h0;
      step_ff <= 3'h0;
      smp_ff <= 3'h0;
      rb_left_ff <= 3'h0;
      asm_ff <= 20'h0_0000;
      cnt_ff <= CNT_RESET;
      stop_ff <= 20'h0_0000;
      wval_ff <= 20'h0_0000;
      rb_ff <= 20'h0_0000;
      idx_ff <= IDX_INIT;
      wbase_ff <= 8'h00;
      init_addr_ff <= 8'h00;
      rate_ff <= RATE_RESET;
      ovf_en_ff <= 1'b1;
      rec_mode_ff <= 1'b0;
      full_ff <= 1'b0;
      label_ff <= 1'b0;
      go_run_ff <= 1'b0;
      fetch_pend_ff <= 1'b0;
      ram_req_ff <= '0;
    end else if (init_req) begin
      state_ff <= S_INIT;
      init_addr_ff <= 8'h00;
      ram_req_ff <= '0;
    end else begin
      ram_req_ff.we <= 1'b0;
      ram_req_ff.re <= 1'b0;
      fetch_pend_ff <= 1'b0;
      unique case (state_ff)
        S_INIT: begin
          ram_req_ff <= '{addr: {12'h000, init_addr_ff}, wdata: 8'h00, we: 1'b1, re: 1'b0};
          init_addr_ff <= init_addr_ff + 8'h01;
          if (init_addr_ff == IDX_LAST) begin
            cnt_ff <= CNT_RESET;
            rec_mode_ff <= 1'b0;
            rate_ff <= RATE_RESET;
            full_ff <= 1'b0;
            idx_ff <= IDX_INIT;
            ovf_en_ff <= 1'b1;
            label_ff <= 1'b0;
            state_ff <= S_IDLE;
          end
        end
        S_IDLE: begin
          nib_cnt_ff <= 3'h0;
          step_ff <= 3'h0;
          smp_ff <= 3'h0;
          if (wr_evt) begin
            cmd_ff <= nib_s2_ff;
            unique case (nib_s2_ff)
              CMD_PLAY: begin
                rec_mode_ff <= 1'b0;
                full_ff <= 1'b0;
              end
              CMD_START: begin
                label_ff <= 1'b0;
                state_ff <= S_RUN;
              end
              CMD_LD_START, CMD_LD_END: begin
                need_ff <= NIB_ADDR;
                state_ff <= S_DATA;
              end
              CMD_CFG: begin
                need_ff <= NIB_CFG;
                state_ff <= S_DATA;
              end
              CMD_SLOT, CMD_STORE: begin
                need_ff <= NIB_TWO;
                state_ff <= S_DATA;
              end
              CMD_RDBACK: begin
                rb_ff <= cnt_ff;
                rb_left_ff <= NIB_ADDR;
                state_ff <= S_READ;
              end
              CMD_CAPTURE: rec_mode_ff <= 1'b1;
              CMD_FETCH: begin
                ram_req_ff.addr <= cnt_ff;
                ram_req_ff.re <= 1'b1;
                fetch_pend_ff <= 1'b1;
                rb_left_ff <= NIB_TWO;
                state_ff <= S_READ;
              end
              default: ; // stop while idle and undefined codes are ignored
            endcase
          end
        end
        S_DATA: begin
          if (wr_evt) begin
            asm_ff <= nxt_asm;
            nib_cnt_ff <= nib_cnt_ff + 3'h1;
            if (nib_cnt_ff + 3'h1 == need_ff) begin
              state_ff <= S_IDLE;
              unique case (cmd_ff)
                CMD_LD_START: cnt_ff <= nxt_asm;
                CMD_LD_END: stop_ff <= nxt_asm;
                CMD_CFG: begin
                  rate_ff <= nxt_asm[CFG_RATE+1:CFG_RATE];
                  ovf_en_ff <= nxt_asm[CFG_OVF];
                end
                CMD_SLOT: begin
                  label_ff <= 1'b1;
                  idx_ff <= slot_base + IDX_STEP;
                  wbase_ff <= slot_base;
                  if (rec_mode_ff) begin
                    wval_ff <= cnt_ff;
                    go_run_ff <= 1'b1;
                    state_ff <= S_IDXWR;
                  end else begin
                    state_ff <= S_IDXRD;
                  end
                end
                default: begin
                  ram_req_ff <= '{addr: cnt_ff, wdata: nxt_asm[19:12], we: 1'b1, re: 1'b0};
                  rec_mode_ff <= 1'b0;
                end
              endcase
            end
          end
        end
        S_IDXWR: begin
          ram_req_ff <= '{addr: {12'h000, wbase_ff + {5'h00, step_ff}},
                          wdata: byte_of(wval_ff, step_ff[1:0]), we: 1'b1, re: 1'b0};
          step_ff <= step_ff + 3'h1;
          if (step_ff == 3'h2) begin
            step_ff <= 3'h0;
            state_ff <= go_run_ff ? S_RUN : S_IDLE;
            go_run_ff <= 1'b0;
          end
        end
        S_IDXRD: begin
          ram_req_ff.addr <= {12'h000, wbase_ff + {5'h00, step_ff}};
          ram_req_ff.re <= 1'b1;
          step_ff <= step_ff + 3'h1;
          if (step_ff != 3'h0 && prev_step[1:0] != 2'h3) begin
            if (prev_step[2]) stop_ff <= put_byte(stop_ff, prev_step[1:0], ram_rdata_in);
            else cnt_ff <= put_byte(cnt_ff, prev_step[1:0], ram_rdata_in);
          end
          if (step_ff == 3'h7) state_ff <= S_RUN;
        end
        S_RUN: begin
          if (ovf_hit) begin
            full_ff <= 1'b1;
            wval_ff <= cnt_ff;
            wbase_ff <= idx_ff;
            state_ff <= label_ff ? S_IDXWR : S_IDLE;
          end else if (cmp_hit) begin
            if (rec_mode_ff) begin
              wval_ff <= cnt_ff;
              wbase_ff <= idx_ff;
              idx_ff <= idx_ff + IDX_STEP;
              state_ff <= S_IDXWR;
            end else begin
              state_ff <= S_IDLE;
            end
          end else if (stop_cmd) begin
            if (label_ff && rec_mode_ff) begin
              wval_ff <= cnt_ff;
              wbase_ff <= idx_ff;
              state_ff <= S_IDXWR;
            end else if (label_ff) begin
              state_ff <= S_PAUSE;
            end else begin
              state_ff <= S_IDLE;
            end
          end else if (sample_tick_in) begin
            smp_ff <= smp_ff + 3'h1;
            if (smp_ff == SMP_LAST) cnt_ff <= cnt_ff + 20'h0_0001;
          end
        end
        S_PAUSE: begin
          if (start_cmd) state_ff <= S_RUN;
          else if (stop_cmd) state_ff <= S_IDLE;
        end
        S_READ: begin
          if (fetch_pend_ff) rb_ff <= {12'h000, ram_rdata_in};
          if (rd_evt) begin
            rb_ff <= {4'h0, rb_ff[19:4]};
            rb_left_ff <= rb_left_ff - 3'h1;
            if (rb_left_ff == 3'h1) begin
              rec_mode_ff <= 1'b0;
              state_ff <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // status and nibble bus driver
  logic busy;
  assign busy = state_ff inside {S_INIT, S_DATA, S_IDXWR, S_IDXRD};
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      status_ff <= 4'h2;
      nib_out_ff <= 4'h0;
      nib_oe_n_ff <= 1'b1;
    end else begin
      status_ff[SB_AMP] <= amplitude_in & rec_mode_ff & (state_ff == S_RUN);
      status_ff[SB_FULL] <= full_ff;
      status_ff[SB_BUSY] <= busy;
      status_ff[SB_ACT] <= state_ff == S_RUN;
      nib_out_ff <= (state_ff == S_READ) ? rb_ff[3:0] : status_ff;
      nib_oe_n_ff <= rd_s2_ff | ~mode_s2_ff;
    end
  end

  // axi4-lite slave
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      host_en_ff <= 1'b1;
      soft_init_ff <= 1'b0;
    end else begin
      soft_init_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      if (bvalid_ff && s_axi_bready_in) bvalid_ff <= 1'b0;
      if (s_axi_awvalid_in && s_axi_wvalid_in && !awready_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
      if (awready_ff) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= RESP_OKAY;
        if (s_axi_awaddr_in == REG_CTRL) begin
          if (s_axi_wstrb_in[0]) begin
            host_en_ff <= s_axi_wdata_in[CTRL_HOST_EN];
            soft_init_ff <= s_axi_wdata_in[CTRL_INIT];
          end
        end else if (!(s_axi_awaddr_in inside {REG_STATUS, REG_COUNTER, REG_STOP, REG_INDEX}))
          bresp_ff <= RESP_DECERR;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      arready_ff <= s_axi_arvalid_in && !arready_ff && !rvalid_ff;
      if (rvalid_ff && s_axi_rready_in) rvalid_ff <= 1'b0;
      if (arready_ff) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= RESP_OKAY;
        unique case (s_axi_araddr_in)
          REG_CTRL: rdata_ff <= {31'h0000_0000, host_en_ff};
          REG_STATUS: rdata_ff <= {23'h00_0000, mode_s2_ff, rec_mode_ff, ovf_en_ff,
                                   rate_ff, status_ff};
          REG_COUNTER: rdata_ff <= {12'h000, cnt_ff};
          REG_STOP: rdata_ff <= {12'h000, stop_ff};
          REG_INDEX: rdata_ff <= {24'h00_0000, idx_ff};
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_DECERR;
          end
        endcase
      end
    end
  end

  assign host_nibble_bus_out = nib_out_ff;
  assign host_nibble_bus_oe_n_out = nib_oe_n_ff;
  assign ram_req_out = ram_req_ff;
  assign rate_sel_out = rate_ff;
  assign record_mode_out = rec_mode_ff;
  assign codec_run_out = status_ff[SB_ACT];
  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign s_axi_rdata_out = rdata_ff;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in | init_req);

  logic idle_cmd;
  assign idle_cmd = (state_ff == S_IDLE) & wr_evt;
  property p_play_clears;
    idle_cmd && nib_s2_ff == CMD_PLAY |=> !full_ff && !rec_mode_ff;
  endproperty
  a_play_clears: assert property (p_play_clears) else $error("play cmd left flags");
  property p_start_runs;
    idle_cmd && nib_s2_ff == CMD_START |=> state_ff == S_RUN ##1 status_ff[SB_ACT];
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("start did not run");
  property p_capture;
    idle_cmd && nib_s2_ff == CMD_CAPTURE |=> rec_mode_ff;
  endproperty
  a_capture: assert property (p_capture) else $error("capture mode not set");
  property p_step8;
    state_ff == S_RUN && !ovf_hit && !cmp_hit && !stop_cmd && sample_tick_in
      && smp_ff == 3'h7 |=> cnt_ff == $past(cnt_ff) + 20'h0_0001;
  endproperty
  a_step8: assert property (p_step8) else $error("counter missed step");
  property p_ovf_stop;
    state_ff == S_RUN && ovf_hit |=> state_ff != S_RUN && full_ff;
  endproperty
  a_ovf_stop: assert property (p_ovf_stop) else $error("overflow did not stop");
  property p_forced_stop;
    state_ff == S_RUN && !label_ff && !ovf_hit && !cmp_hit && stop_cmd
      |=> state_ff == S_IDLE && !ram_req_ff.we;
  endproperty
  a_forced_stop: assert property (p_forced_stop) else $error("forced stop wrote");
  property p_busy;
    state_ff == S_DATA |=> status_ff[SB_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early");
  property p_init_end;
    state_ff == S_INIT && init_addr_ff == IDX_LAST
      |=> cnt_ff == CNT_RESET && !rec_mode_ff && rate_ff == RATE_RESET && !full_ff;
  endproperty
  a_init_end: assert property (p_init_end) else $error("init values wrong");
  sequence s_index_fetch;
    (state_ff == S_IDXRD && ram_req_ff.re)[*7] ##1 state_ff == S_RUN;
  endsequence
  property p_slot_play;
    state_ff == S_IDXRD && step_ff == 3'h0 |=> s_index_fetch;
  endproperty
  a_slot_play: assert property (p_slot_play) else $error("index fetch broken");
  property p_drive;
    !rd_s2_ff && mode_s2_ff |=> !host_nibble_bus_oe_n_out;
  endproperty
  a_drive: assert property (p_drive) else $error("nibble bus not driven");
endmodule : vrh_command_unit
`default_nettype wire

// file: hw/vrh_pkg.sv
// How it works
// - with host mode high, eleven nibble commands arrive via write and read strobes
// - playback_mode_cmd selects playback and clears ram_full_flag
// - START begins direct-mode run from current address counter
// - STOP halts; slot recording first stores counter as phrase end entry
// - STOP pauses slot playback; START resumes; second STOP returns to waiting
// - start_addr_load_cmd loads counter from five nibbles, lowest first
// - end_addr_load_cmd loads stop address from five nibbles, lowest first
// - config_cmd low two bits select 8, 11, 16 or 32 kbps
// - config_cmd bit 2 enables overflow auto stop; host sends bit 3 zero
// - phrase_slot_cmd in recording stores counter as phrase start, then records
// - phrase_slot_cmd in playback fetches start and end from index, then plays
// - counter_readback_cmd returns counter over five reads; status hidden meanwhile
// - capture_mode_cmd selects recording mode
// - ram_byte_fetch_cmd returns RAM byte at counter over two reads
// - ram_byte_store_cmd writes two-nibble byte at counter, counter unchanged
// - counter advances by one after every eight codec samples
// - direct recording ending on match writes end entry, index advances
// - overflow detector stops recording at final RAM address when enabled
// - forced STOP in direct recording writes no index entry
// - status nibble amplitude, full, busy, active driven while read strobe low
// - busy holds until last data nibble of multi-nibble command arrives
// - init clears index 0..FE, counter 100h, playback, 8 kbps, full cleared
package vrh_pkg;
  localparam int ADDR_W = 20;
  localparam logic [3:0] CMD_PLAY = 4'h1;
  localparam logic [3:0] CMD_START = 4'h2;
  localparam logic [3:0] CMD_STOP = 4'h3;
  localparam logic [3:0] CMD_LD_START = 4'h4;
  localparam logic [3:0] CMD_LD_END = 4'h5;
  localparam logic [3:0] CMD_CFG = 4'h6;
  localparam logic [3:0] CMD_SLOT = 4'h7;
  localparam logic [3:0] CMD_RDBACK = 4'h8;
  localparam logic [3:0] CMD_CAPTURE = 4'h9;
  localparam logic [3:0] CMD_FETCH = 4'hA;
  localparam logic [3:0] CMD_STORE = 4'hB;
  localparam logic [2:0] NIB_ADDR = 3'h5;
  localparam logic [2:0] NIB_CFG = 3'h1;
  localparam logic [2:0] NIB_TWO = 3'h2;
  localparam logic [2:0] SMP_LAST = 3'h7;
  localparam logic [19:0] CNT_RESET = 20'h0_0100;
  localparam logic [19:0] RAM_LAST_DEF = 20'hF_FFFF;
  localparam logic [7:0] IDX_LAST = 8'hFE;
  localparam logic [7:0] IDX_INIT = 8'h04;
  localparam logic [7:0] IDX_STEP = 8'h04;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam int SB_AMP = 3;
  localparam int SB_FULL = 2;
  localparam int SB_BUSY = 1;
  localparam int SB_ACT = 0;
  localparam int CFG_RATE = 16;
  localparam int CFG_OVF = 18;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNTER = 8'h08;
  localparam logic [7:0] REG_STOP = 8'h0C;
  localparam logic [7:0] REG_INDEX = 8'h10;
  localparam int CTRL_HOST_EN = 0;
  localparam int CTRL_INIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    S_INIT, S_IDLE, S_DATA, S_IDXWR, S_IDXRD, S_RUN, S_PAUSE, S_READ
  } vrh_state_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } vrh_ram_req_t;
endpackage : vrh_pkg

// file: tb/test_voice_recorder_host_command_unit.sv
`timescale 1ns/100ps
`default_nettype none
module test_voice_recorder_host_command_unit import vrh_pkg::*;;
  logic ref_clk_in, rst_in, host_mode_pin_in, init_pulse_pin_n_in, host_wr_n_in, host_rd_n_in;
  logic sample_tick_in, amplitude_in, host_nibble_bus_oe_n_out, record_mode_out, codec_run_out;
  logic [3:0] host_nibble_bus_in, host_nibble_bus_out, s_axi_wstrb_in, nb;
  logic [7:0] ram_rdata_in, s_axi_awaddr_in, s_axi_araddr_in, byt;
  logic [1:0] rate_sel_out, s_axi_bresp_out, s_axi_rresp_out, rs;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd, tmp;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic [19:0] a_val, e_val;
  logic [5:0] ph;
  vrh_ram_req_t ram_req_out;
  int miscompares, samples_checked, seed, i;
  vrh_command_unit u_dut (.ref_clk_in, .rst_in, .host_mode_pin_in, .init_pulse_pin_n_in,
    .host_nibble_bus_in, .host_nibble_bus_out, .host_nibble_bus_oe_n_out, .host_wr_n_in,
    .host_rd_n_in, .sample_tick_in, .amplitude_in, .ram_rdata_in, .ram_req_out, .rate_sel_out,
    .record_mode_out, .codec_run_out, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in);
  vrh_ram_model u_ram (.ref_clk_in, .ram_req_in(ram_req_out), .ram_rdata_out(ram_rdata_in));
  function automatic logic [3:0] nib(input logic [19:0] v, input int k);
    return v[4*k+:4];
  endfunction : nib
  function automatic logic [23:0] entry(input int b);
    return {u_ram.mem[b+2], u_ram.mem[b+1], u_ram.mem[b]};
  endfunction : entry
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : axi_rd
  task hw(input logic [3:0] v);
    host_nibble_bus_in <= v;
    @(posedge ref_clk_in);
    host_wr_n_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    host_wr_n_in <= 1'b1;
    repeat (14) @(posedge ref_clk_in);
  endtask : hw
  task hr(output logic [3:0] v);
    host_rd_n_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    v = host_nibble_bus_out;
    check(host_nibble_bus_oe_n_out, 1'b0);
    host_rd_n_in <= 1'b1;
    repeat (14) @(posedge ref_clk_in);
  endtask : hr
  task load5(input logic [3:0] c, input logic [19:0] v);
    hw(c);
    axi_rd(REG_STATUS, rd, rs);
    check(rd[SB_BUSY], 1'b1);
    for (int k = 0; k < 5; k++) hw(nib(v, k));
  endtask : load5
  task readback(input logic [19:0] v);
    hw(CMD_RDBACK);
    for (int k = 0; k < 5; k++) begin
      hr(nb);
      check(nb, nib(v, k));
    end
  endtask : readback
  task ticks(input int n);
    repeat (n) begin
      sample_tick_in <= 1'b1;
      @(posedge ref_clk_in);
      sample_tick_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
    end
  endtask : ticks
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    miscompares++;
    stop_test();
  end
  initial begin
    {rst_in, host_mode_pin_in, init_pulse_pin_n_in, host_wr_n_in, host_rd_n_in} = 5'h1F;
    {sample_tick_in, amplitude_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 5'h00;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = 18'h0_0000;
    {host_nibble_bus_in, s_axi_wdata_in, s_axi_wstrb_in} = {4'h0, 32'h0000_0000, 4'hF};
    seed = 32'ha2dd;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (300) @(posedge ref_clk_in);
    axi_wr(REG_COUNTER, 32'hFFFF_FFFF, rs);
    check(rs, RESP_OKAY);
    axi_rd(REG_COUNTER, rd, rs);
    check(rd[19:0], CNT_RESET);
    check({rate_sel_out, record_mode_out}, 3'h0);
    axi_rd(8'h20, rd, rs);
    check(rs, RESP_DECERR);
    check(rd, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      hw(CMD_CFG);
      hw({1'b0, i[0], i[1:0]});
      check(rate_sel_out, i[1:0]);
      axi_rd(REG_STATUS, rd, rs);
      check(rd[6], i[0]);
    end
    axi_wr(REG_CTRL, 32'h0000_0000, rs);
    hw(CMD_CAPTURE);
    check(record_mode_out, 1'b0);
    axi_wr(REG_CTRL, 32'h0000_0001, rs);
    hw(CMD_CAPTURE);
    check(record_mode_out, 1'b1);
    hw(CMD_PLAY);
    check(record_mode_out, 1'b0);
    tmp = $random(seed);
    a_val = {4'h1, tmp[15:0]};
    byt = tmp[23:16];
    e_val = a_val + 20'h0_0002;
    load5(CMD_LD_START, a_val);
    axi_rd(REG_COUNTER, rd, rs);
    check(rd[19:0], a_val);
    load5(CMD_LD_END, e_val);
    axi_rd(REG_STOP, rd, rs);
    check(rd[19:0], e_val);
    readback(a_val);
    hw(CMD_STORE);
    hw(byt[3:0]);
    hw(byt[7:4]);
    check(u_ram.mem[a_val], byt);
    hw(CMD_FETCH);
    hr(nb);
    check(nb, byt[3:0]);
    hr(nb);
    check(nb, byt[7:4]);
    axi_rd(REG_COUNTER, rd, rs);
    check(rd[19:0], a_val);
    hw(CMD_CAPTURE);
    hw(CMD_START);
    check(codec_run_out, 1'b1);
    hr(nb);
    check(nb[SB_ACT], 1'b1);
    ticks(8);
    axi_rd(REG_COUNTER, rd, rs);
    check(rd[19:0], a_val + 20'h0_0001);
    ticks(8);
    repeat (10) @(posedge ref_clk_in);
    check(codec_run_out, 1'b0);
    axi_rd(REG_INDEX, rd, rs);
    check(rd[7:0], IDX_INIT + IDX_STEP);
    check({u_ram.mem[IDX_INIT + 1], u_ram.mem[IDX_INIT]}, e_val[15:0]);
    load5(CMD_LD_START, a_val);
    hw(CMD_START);
    ticks(8);
    hw(CMD_STOP);
    check(codec_run_out, 1'b0);
    axi_rd(REG_INDEX, rd, rs);
    check(rd[7:0], IDX_INIT + IDX_STEP);
    readback(a_val + 20'h0_0001);
    ph = {1'b0, tmp[28:24]};
    hw(CMD_CAPTURE);
    hw(CMD_SLOT);
    hw(ph[3:0]);
    hw({2'h0, ph[5:4]});
    check(codec_run_out, 1'b1);
    amplitude_in <= 1'b1;
    hr(nb);
    check(nb[SB_AMP], 1'b1);
    ticks(8);
    hw(CMD_STOP);
    check(codec_run_out, 1'b0);
    check(entry(4 * ph), {4'h0, a_val + 20'h0_0001});
    check(entry(4 * ph + 4), {4'h0, e_val});
    hw(CMD_PLAY);
    hw(CMD_SLOT);
    hw(ph[3:0]);
    hw({2'h0, ph[5:4]});
    axi_rd(REG_STOP, rd, rs);
    check(rd[19:0], e_val);
    hw(CMD_STOP);
    check(codec_run_out, 1'b0);
    hw(CMD_START);
    check(codec_run_out, 1'b1);
    ticks(8);
    check(codec_run_out, 1'b0);
    hw(CMD_CAPTURE);
    load5(CMD_LD_START, RAM_LAST_DEF);
    hw(CMD_START);
    hr(nb);
    check(nb[SB_FULL], 1'b1);
    hw(CMD_PLAY);
    hr(nb);
    check(nb[SB_FULL], 1'b0);
    stop_test();
  end
endmodule : test_voice_recorder_host_command_unit
`default_nettype wire

// file: tb/vrh_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
module vrh_ram_model import vrh_pkg::*; (
  input wire logic ref_clk_in,
  input wire vrh_ram_req_t ram_req_in,
  output logic [7:0] ram_rdata_out
);
  logic [7:0] mem [0:1048575];
  logic [7:0] last_ff;
  always_ff @(posedge ref_clk_in) begin
    if (ram_req_in.we) mem[ram_req_in.addr] <= ram_req_in.wdata;
    if (ram_req_in.re) last_ff <= mem[ram_req_in.addr];
  end
  // asynchronous read; released bus shows the inverse of the last byte
  assign ram_rdata_out = ram_req_in.re ? mem[ram_req_in.addr] : ~last_ff;
endmodule : vrh_ram_model
`default_nettype wire
